// ===== verilog/pbc_host.sv
/*
  Integration/software end: takes a desired multiplier, vco frequency and
  reference divider on a command port, derives the prescale, range power
  and linear multiplier, then programs the clock generator in a safe
  order. Also drives the oscillator enable from the stop-mode input.
  Assumes the clock generator shares core_clk.
*/
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module pbc_host
  import pbc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  pbc_if.host              bus,
  input  wire logic [2:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic [31:0]      cmd_rdata,
  input  wire logic        stop_mode
);

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0000,
    H_DIV   = 4'b0001,
    H_CHK   = 4'b0011,
    H_DESEL = 4'b0010,
    H_OFF   = 4'b0110,
    H_MSH   = 4'b0111,
    H_MSL   = 4'b0101,
    H_MRS   = 4'b0100,
    H_MDS   = 4'b1100,
    H_ON    = 4'b1101,
    H_SEL   = 4'b1111
  } pbc_hst_t;

  pbc_hst_t    st_q, st_d;
  logic [14:0] nraw_q, nraw_d;
  logic [18:0] freq_q, freq_d;
  logic [3:0]  rdiv_q, rdiv_d;
  logic [1:0]  p_q, p_d;
  logic [1:0]  e_q, e_d;
  logic [11:0] n_q, n_d;
  logic [7:0]  l_q, l_d;
  logic [19:0] rem_q, rem_d;
  logic [10:0] dvs_q, dvs_d;
  logic        err_q, err_d;
  logic        done_q, done_d;
  logic        xtal_q, xtal_d;
  logic        wr_q, wr_d;
  logic [7:0]  addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic [31:0] rdata_q, rdata_d;
  logic        osc_q;
  logic [14:0] nround;
  logic [18:0] fvrs;
  logic [18:0] diff;
  logic [7:0]  ctrl_base;

  function automatic logic [1:0] pick_pre(input logic [14:0] n);
    if (n <= {3'b000, MULT_MAX}) pick_pre = 2'h0;
    else if (n <= {2'b00, MULT_MAX, 1'b0}) pick_pre = 2'h1;
    else if (n <= {1'b0, MULT_MAX, 2'b00}) pick_pre = 2'h2;
    else pick_pre = 2'h3;
  endfunction

  function automatic logic [1:0] pick_range(input logic [18:0] f);
    if (f < F_RANGE1) pick_range = 2'h0;
    else if (f < F_RANGE2) pick_range = 2'h1;
    else pick_range = 2'h2;
  endfunction

  always_comb begin
    st_d    = st_q;
    nraw_d  = nraw_q;
    freq_d  = freq_q;
    rdiv_d  = rdiv_q;
    p_d     = p_q;
    e_d     = e_q;
    n_d     = n_q;
    l_d     = l_q;
    rem_d   = rem_q;
    dvs_d   = dvs_q;
    err_d   = err_q;
    done_d  = done_q;
    xtal_d  = xtal_q;
    wr_d    = 1'b0;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    nround  = 15'h0000;
    fvrs    = 19'h00000;
    diff    = 19'h00000;
    ctrl_base = {4'h0, p_q, e_q};
    if (cmd_rd) begin
      rdata_d = (cmd_addr == HOST_STATUS)
        ? {4'h0, n_q, l_q, e_q, p_q, 1'b0, done_q, err_q, st_q != H_IDLE}
        : 32'h0000_0000;
    end
    case (st_q)
      H_IDLE: begin
        if (cmd_wr) begin
          case (cmd_addr)
            HOST_MULT:   nraw_d = cmd_wdata[14:0];
            HOST_FREQ:   freq_d = cmd_wdata[18:0];
            HOST_REFDIV: rdiv_d = cmd_wdata[3:0];
            HOST_CMD: begin
              done_d = 1'b0;
              err_d  = 1'b0;
              xtal_d = cmd_wdata[CMD_XTAL_BIT];
              if (cmd_wdata[CMD_XTAL_BIT]) begin
                st_d = H_DESEL;
              end else if (cmd_wdata[CMD_GO_BIT]) begin
                p_d    = pick_pre(nraw_q);
                nround = (nraw_q + ((15'h0001 << pick_pre(nraw_q))
                          >> 1)) >> pick_pre(nraw_q);
                n_d    = nround[11:0];
                e_d    = pick_range(freq_q);
                dvs_d  = F_NOM << pick_range(freq_q);
                rem_d  = {1'b0, freq_q}
                         + {9'h000, F_NOM << pick_range(freq_q) >> 1};
                l_d    = 8'h00;
                st_d   = H_DIV;
              end
            end
            default: ;
          endcase
        end
      end
      H_DIV: begin
        if (rem_q >= {9'h000, dvs_q} && l_q != 8'hFF) begin
          rem_d = rem_q - {9'h000, dvs_q};
          l_d   = l_q + 8'h01;
        end else begin
          st_d = H_CHK;
        end
      end
      H_CHK: begin
        fvrs = 19'(l_q * dvs_q);
        diff = (fvrs > freq_q) ? fvrs - freq_q : freq_q - fvrs;
        if (freq_q == 19'h00000 || freq_q >= F_RANGE_TOP
            || l_q == 8'h00 || diff > {9'h000, dvs_q >> 1}) begin
          err_d = 1'b1;
          st_d  = H_IDLE;
        end else begin
          st_d = H_DESEL;
        end
      end
      H_DESEL: begin
        wr_d    = 1'b1;
        addr_d  = ADDR_PLL_CTRL;
        wdata_d = ctrl_base | (8'h01 << PLL_ON_BIT);
        if (xtal_q) begin
          done_d = 1'b1;
          st_d   = H_IDLE;
        end else begin
          st_d = H_OFF;
        end
      end
      H_OFF: begin
        wr_d    = 1'b1;
        addr_d  = ADDR_PLL_CTRL;
        wdata_d = ctrl_base;
        st_d    = H_MSH;
      end
      H_MSH: begin
        wr_d    = 1'b1;
        addr_d  = ADDR_MULT_HIGH;
        wdata_d = {4'h0, n_q[11:8]};
        st_d    = H_MSL;
      end
      H_MSL: begin
        wr_d    = 1'b1;
        addr_d  = ADDR_MULT_LOW;
        wdata_d = n_q[7:0];
        st_d    = H_MRS;
      end
      H_MRS: begin
        wr_d    = 1'b1;
        addr_d  = ADDR_VCO_RANGE;
        wdata_d = l_q;
        st_d    = H_MDS;
      end
      H_MDS: begin
        wr_d    = 1'b1;
        addr_d  = ADDR_REF_DIV;
        wdata_d = {4'h0, rdiv_q};
        st_d    = H_ON;
      end
      H_ON: begin
        wr_d    = 1'b1;
        addr_d  = ADDR_PLL_CTRL;
        wdata_d = ctrl_base | (8'h01 << PLL_ON_BIT);
        st_d    = H_SEL;
      end
      H_SEL: begin
        wr_d    = 1'b1;
        addr_d  = ADDR_PLL_CTRL;
        wdata_d = ctrl_base | (8'h01 << PLL_ON_BIT)
                  | (8'h01 << BCS_BIT);
        done_d  = 1'b1;
        st_d    = H_IDLE;
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= H_IDLE;
      nraw_q  <= 15'h0000;
      freq_q  <= 19'h00000;
      rdiv_q  <= 4'h1;
      p_q     <= 2'h0;
      e_q     <= 2'h0;
      n_q     <= 12'h000;
      l_q     <= 8'h00;
      rem_q   <= 20'h00000;
      dvs_q   <= 11'h000;
      err_q   <= 1'b0;
      done_q  <= 1'b0;
      xtal_q  <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      osc_q   <= 1'b1;
    end else if (ce) begin
      st_q    <= st_d;
      nraw_q  <= nraw_d;
      freq_q  <= freq_d;
      rdiv_q  <= rdiv_d;
      p_q     <= p_d;
      e_q     <= e_d;
      n_q     <= n_d;
      l_q     <= l_d;
      rem_q   <= rem_d;
      dvs_q   <= dvs_d;
      err_q   <= err_d;
      done_q  <= done_d;
      xtal_q  <= xtal_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      osc_q   <= ~stop_mode;
    end
  end

  assign bus.wr    = wr_q;
  assign bus.rd    = 1'b0;
  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.osc_enable_from_integration = osc_q;
  assign cmd_rdata = rdata_q;

endmodule

// ===== verilog/pbc_pkg.sv
/*
  Shared constants of the PLL base clock select block: device register
  addresses, field positions, reset values, host command map and the
  figures that software uses to program the loop.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pbc_pkg;

  // device register addresses on the 8-bit programming port
  localparam logic [7:0] ADDR_PLL_CTRL   = 8'h36;
  localparam logic [7:0] ADDR_MULT_HIGH  = 8'h38;
  localparam logic [7:0] ADDR_MULT_LOW   = 8'h39;
  localparam logic [7:0] ADDR_VCO_RANGE  = 8'h3A;
  localparam logic [7:0] ADDR_REF_DIV    = 8'h3B;

  // control register fields
  localparam int PLL_ON_BIT   = 5;
  localparam int BCS_BIT      = 4;
  localparam int PRE_LSB      = 2;
  localparam int VPR_LSB      = 0;

  // reset values
  localparam logic       RST_PLL_ON     = 1'b1;
  localparam logic       RST_BCS        = 1'b0;
  localparam logic [3:0] RST_MULT_HIGH  = 4'h0;
  localparam logic [7:0] RST_MULT_LOW   = 8'h40;
  localparam logic [7:0] RST_VCO_RANGE  = 8'h40;
  localparam logic [3:0] RST_REF_DIV    = 4'h1;

  // source switch waits this many edges of the crystal clock, and of the vco clock while pll_enable is set
  localparam logic [1:0] SW_EDGES       = 2'h3;

  // host command port map
  localparam logic [2:0] HOST_CMD       = 3'h0;
  localparam logic [2:0] HOST_MULT      = 3'h1;
  localparam logic [2:0] HOST_FREQ      = 3'h2;
  localparam logic [2:0] HOST_REFDIV    = 3'h3;
  localparam logic [2:0] HOST_STATUS    = 3'h4;
  localparam int CMD_GO_BIT      = 0;
  localparam int CMD_XTAL_BIT    = 1;

  // multiplier limit; frequencies in units of 100 Hz
  localparam logic [11:0] MULT_MAX      = 12'hFFF;
  localparam logic [10:0] F_NOM         = 11'h180;   // 38.4 kHz
  localparam logic [18:0] F_RANGE1      = 19'h13880; // 8 MHz
  localparam logic [18:0] F_RANGE2      = 19'h27100; // 16 MHz
  localparam logic [18:0] F_RANGE_TOP   = 19'h4E200; // 32 MHz

endpackage

// ===== verilog/pbc_if.sv
/*
  Link between the clock generator and the integration/software side:
  byte-wide programming port, oscillator enable, base clock.
  Assumes a single core clock shared by both ends.
*/
`timescale 1ns/1ns
interface pbc_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       osc_enable_from_integration;
  logic       base_clock_out;

  modport dev (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    input  osc_enable_from_integration,
    output base_clock_out
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    output osc_enable_from_integration,
    input  base_clock_out
  );
endinterface

// ===== verilog/pbc_clock_gen.sv
/*
  Clock generator end: programming registers with their interlocks,
  oscillator and PLL enables, and the glitch-free source switch with the
  divide-by-two that forms the base clock.
  Assumes crystal and vco clocks are slow against core_clk (below a
  quarter of it) and arrive asynchronously; the base clock is rebuilt in
  the core_clk domain from their sampled edges.
*/
`timescale 1ns/1ns
module pbc_clock_gen
  import pbc_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  rstn,
  input  wire logic  ce,
  pbc_if.dev         bus,
  input  wire logic  crystal_clock,
  input  wire logic  vco_clock,
  input  wire logic  osc_run_in_stop,
  output logic       osc_enable,
  output logic       pll_enable,
  output logic [1:0] pre_power,
  output logic [1:0] vco_range_power,
  output logic [7:0] vco_range,
  output logic [11:0] mult_eff,
  output logic [3:0] ref_div_eff,
  output logic       switching
);

  typedef enum logic {SW_RUN = 1'b0, SW_WAIT = 1'b1} pbc_sw_t;

  logic        pll_on_q, pll_on_d;
  logic        bcs_q, bcs_d;
  logic [1:0]  pre_q, pre_d;
  logic [1:0]  vpr_q, vpr_d;
  logic [3:0]  msh_q, msh_d;
  logic [7:0]  msl_q, msl_d;
  logic [7:0]  mrs_q, mrs_d;
  logic [3:0]  mds_q, mds_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [11:0] mult_q, mult_d;
  logic [3:0]  rdiv_q, rdiv_d;
  logic        new_on;
  logic        new_bcs;

  logic [2:0]  xs_q;
  logic [2:0]  vs_q;
  logic        x_edge;
  logic        v_edge;
  pbc_sw_t     sw_q, sw_d;
  logic        sel_q, sel_d;
  logic [1:0]  xcnt_q, xcnt_d;
  logic [1:0]  vcnt_q, vcnt_d;
  logic        out_q, out_d;
  logic [1:0]  ris_q;

  function automatic logic [11:0] zero_as_one12(input logic [11:0] v);
    zero_as_one12 = (v == 12'h000) ? 12'h001 : v;
  endfunction

  // register file and interlocks
  always_comb begin
    pll_on_d = pll_on_q;
    bcs_d    = bcs_q;
    pre_d    = pre_q;
    vpr_d    = vpr_q;
    msh_d    = msh_q;
    msl_d    = msl_q;
    mrs_d    = mrs_q;
    mds_d    = mds_q;
    rdata_d  = 8'h00;
    new_on   = bus.wdata[PLL_ON_BIT];
    new_bcs  = bus.wdata[BCS_BIT];
    if (bus.wr) begin
      case (bus.addr)
        ADDR_PLL_CTRL: begin
          pre_d = bus.wdata[PRE_LSB +: 2];
          vpr_d = bus.wdata[VPR_LSB +: 2];
          if (!((new_on != pll_on_q) && (new_bcs != bcs_q))) begin
            if (new_on || !bcs_q) begin
              pll_on_d = new_on;
            end
            if (!new_bcs || (pll_on_q && mrs_q != 8'h00)) begin
              bcs_d = new_bcs;
            end
          end
        end
        ADDR_MULT_HIGH: if (!pll_on_q) msh_d = bus.wdata[3:0];
        ADDR_MULT_LOW:  if (!pll_on_q) msl_d = bus.wdata;
        ADDR_VCO_RANGE: if (!pll_on_q) mrs_d = bus.wdata;
        ADDR_REF_DIV:   if (!pll_on_q) mds_d = bus.wdata[3:0];
        default: ;
      endcase
    end
    if (mrs_d == 8'h00) begin
      bcs_d = 1'b0;
    end
    if (bus.rd) begin
      case (bus.addr)
        ADDR_PLL_CTRL:  rdata_d = {2'b00, pll_on_q, bcs_q, pre_q, vpr_q};
        ADDR_MULT_HIGH: rdata_d = {4'h0, msh_q};
        ADDR_MULT_LOW:  rdata_d = msl_q;
        ADDR_VCO_RANGE: rdata_d = mrs_q;
        ADDR_REF_DIV:   rdata_d = {4'h0, mds_q};
        default:        rdata_d = 8'h00;
      endcase
    end
    mult_d = zero_as_one12({msh_q, msl_q});
    rdiv_d = (mds_q == 4'h0) ? 4'h1 : mds_q;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pll_on_q <= RST_PLL_ON;
      bcs_q    <= RST_BCS;
      pre_q    <= 2'h0;
      vpr_q    <= 2'h0;
      msh_q    <= RST_MULT_HIGH;
      msl_q    <= RST_MULT_LOW;
      mrs_q    <= RST_VCO_RANGE;
      mds_q    <= RST_REF_DIV;
      rdata_q  <= 8'h00;
      mult_q   <= {RST_MULT_HIGH, RST_MULT_LOW};
      rdiv_q   <= RST_REF_DIV;
    end else if (ce) begin
      pll_on_q <= pll_on_d;
      bcs_q    <= bcs_d;
      pre_q    <= pre_d;
      vpr_q    <= vpr_d;
      msh_q    <= msh_d;
      msl_q    <= msl_d;
      mrs_q    <= mrs_d;
      mds_q    <= mds_d;
      rdata_q  <= rdata_d;
      mult_q   <= mult_d;
      rdiv_q   <= rdiv_d;
    end
  end

  assign bus.rdata       = rdata_q;
  assign pre_power       = pre_q;
  assign vco_range_power = vpr_q;
  assign vco_range       = mrs_q;
  assign mult_eff        = mult_q;
  assign ref_div_eff     = rdiv_q;
  // option strap is a pin: read only after two flops
  assign osc_enable = bus.osc_enable_from_integration
                      | ris_q[1];
  assign pll_enable = osc_enable & pll_on_q
                      & (mrs_q != 8'h00);

  // sampled clocks; stage 0 feeds only stage 1
  assign x_edge = xs_q[1] & ~xs_q[2];
  assign v_edge = vs_q[1] & ~vs_q[2];

  // source switch and divide-by-two
  always_comb begin
    sw_d   = sw_q;
    sel_d  = sel_q;
    xcnt_d = xcnt_q;
    vcnt_d = vcnt_q;
    out_d  = out_q;
    case (sw_q)
      SW_RUN: begin
        if (bcs_q != sel_q) begin
          sw_d   = SW_WAIT;
          xcnt_d = 2'h0;
          vcnt_d = 2'h0;
        end else if (sel_q ? v_edge : x_edge) begin
          out_d = ~out_q;
        end
      end
      SW_WAIT: begin
        // output held static meanwhile
        if (x_edge && xcnt_q != SW_EDGES) xcnt_d = xcnt_q + 2'h1;
        if (v_edge && vcnt_q != SW_EDGES) vcnt_d = vcnt_q + 2'h1;
        if (xcnt_q == SW_EDGES
            && (vcnt_q == SW_EDGES || !pll_enable)) begin
          sel_d = bcs_q;
          sw_d  = SW_RUN;
        end
      end
      default: sw_d = SW_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xs_q   <= 3'h0;
      ris_q  <= 2'h0;
      vs_q   <= 3'h0;
      sw_q   <= SW_RUN;
      sel_q  <= RST_BCS;
      xcnt_q <= 2'h0;
      vcnt_q <= 2'h0;
      out_q  <= 1'b0;
    end else if (ce) begin
      xs_q   <= {xs_q[1:0], crystal_clock};
      ris_q  <= {ris_q[0], osc_run_in_stop};
      vs_q   <= {vs_q[1:0], vco_clock};
      sw_q   <= sw_d;
      sel_q  <= sel_d;
      xcnt_q <= xcnt_d;
      vcnt_q <= vcnt_d;
      out_q  <= out_d;
    end
  end

  assign bus.base_clock_out = out_q;
  assign switching          = (sw_q == SW_WAIT);

endmodule

// ===== verif/pbc_link_chk.sv
/* Assertions on the host-to-generator link.
   Assumes one core clock and the pbc_pkg register map. */
`timescale 1ns/1ns
module pbc_link_chk
  import pbc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       osc_enable_from_integration,
  input wire logic       base_clock_out
);
  logic [7:0] ctl_q, ctl_d, rng_q, rng_d, idle_q, idle_d;
  logic       bco_q, cw;

  assign cw = wr && addr == ADDR_PLL_CTRL;

  // last control and range bytes written; cycles since base clock moved
  always_comb begin
    ctl_d = cw ? wdata : ctl_q;
    rng_d = (wr && addr == ADDR_VCO_RANGE) ? wdata : rng_q;
    idle_d = idle_q + {7'h00, idle_q != 8'hFF};
    if (base_clock_out != bco_q)
      idle_d = 8'h00;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= {2'h0, RST_PLL_ON, RST_BCS, 4'h0};
      rng_q <= RST_VCO_RANGE;
      idle_q <= 8'h00;
      bco_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      rng_q <= rng_d;
      idle_q <= idle_d;
      bco_q <= base_clock_out;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  property p_reset;
    $rose(rstn) |-> !base_clock_out && osc_enable_from_integration;
  endproperty
  a_reset: assert property (p_reset)
    else $error("base clock or enable wrong after reset");

  property p_half;
    $changed(base_clock_out) |=> $stable(base_clock_out) [*3];
  endproperty
  a_half: assert property (p_half)
    else $error("base clock phase too short");

  property p_alive;
    idle_q < 8'h64;
  endproperty
  a_alive: assert property (p_alive)
    else $error("base clock held too long");

  property p_pair;
    cw |-> !(wdata[PLL_ON_BIT] != ctl_q[PLL_ON_BIT]
             && wdata[BCS_BIT] != ctl_q[BCS_BIT]);
  endproperty
  a_pair: assert property (p_pair)
    else $error("power and source changed in one write");

  property p_sel_on;
    cw && wdata[BCS_BIT] |-> ctl_q[PLL_ON_BIT];
  endproperty
  a_sel_on: assert property (p_sel_on)
    else $error("vco selected with pll off");

  property p_off_xtal;
    cw && !wdata[PLL_ON_BIT] |-> !ctl_q[BCS_BIT];
  endproperty
  a_off_xtal: assert property (p_off_xtal)
    else $error("pll turned off while vco selected");

  property p_prog_off;
    wr && addr inside {[ADDR_MULT_HIGH:ADDR_REF_DIV]}
      |-> !ctl_q[PLL_ON_BIT];
  endproperty
  a_prog_off: assert property (p_prog_off)
    else $error("loop programmed while pll on");

  property p_range;
    cw && wdata[BCS_BIT] |-> rng_q != 8'h00;
  endproperty
  a_range: assert property (p_range)
    else $error("vco selected with zero range");

  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared between reads");
endmodule

// ===== verif/test_pll_base_clock_select.sv
/* Bench: the host end drives one generator over ifa; the bench drives a
   second generator over ifb to break the safe order on purpose.
   Assumes pbc_pkg, pbc_if and both design ends. */
`timescale 1ns/1ns
module test_pll_base_clock_select
  import pbc_pkg::*;
;
  localparam int XH  = 250;
  localparam int VH  = 105;
  localparam int WIN = 200;
  localparam int XE  = WIN * 20 / XH;
  localparam int VE  = WIN * 20 / VH;
  localparam int SWB = (6 * XH + 6 * VH) / 40 + 8;
  logic        core_clk, rstn, stop_mode, run_stop, cmd_wr, cmd_rd;
  logic        oe_a, pe_a, pe_b, sw_b;
  logic        xclk = 1'b0;
  logic        vclk = 1'b0;
  logic [2:0]  cmd_addr;
  logic [31:0] cmd_wdata, cmd_rdata, rv;
  logic [1:0]  pre_a, vpr_a;
  logic [7:0]  rng_a;
  logic [11:0] mul_a, mul_b;
  logic [3:0]  rdv_a, rdv_b;
  int          fails, comparisons, n, ta, tb;
  logic [7:0]  ra [7] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C};
  logic [7:0]  re [7] = '{8'h20, 8'h00, 8'h00, 8'h40, 8'h40, 8'h01, 8'h00};
  logic [31:0] hm [3] = '{32'h258, 32'h2000, 32'h258};
  logic [31:0] hf [3] = '{32'h4E200, 32'h30000, 32'h30000};
  logic [31:0] he [3] = '{32'h2, 32'h080080A4, 32'h02588084};
  pbc_if ifa();
  pbc_if ifb();

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always #(XH) xclk = ~xclk;
  always #(VH) vclk = ~vclk;
  always @(ifa.base_clock_out) ta++;
  always @(ifb.base_clock_out) tb++;

  pbc_clock_gen u_pbc_clock_gen (.core_clk(core_clk), .rstn(rstn),
    .ce(1'b1), .bus(ifa.dev), .crystal_clock(xclk), .vco_clock(vclk),
    .osc_run_in_stop(run_stop), .osc_enable(oe_a), .pll_enable(pe_a),
    .pre_power(pre_a), .vco_range_power(vpr_a), .vco_range(rng_a),
    .mult_eff(mul_a), .ref_div_eff(rdv_a), .switching());
  pbc_clock_gen u_pbc_clock_gen_b (.core_clk(core_clk), .rstn(rstn),
    .ce(1'b1), .bus(ifb.dev), .crystal_clock(xclk), .vco_clock(vclk),
    .osc_run_in_stop(run_stop), .osc_enable(), .pll_enable(pe_b),
    .pre_power(), .vco_range_power(), .vco_range(),
    .mult_eff(mul_b), .ref_div_eff(rdv_b), .switching(sw_b));
  pbc_host u_pbc_host (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
    .bus(ifa.host), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .stop_mode(stop_mode));
  pbc_link_chk u_pbc_link_chk (.core_clk(core_clk), .rstn(rstn),
    .addr(ifa.addr), .wdata(ifa.wdata), .wr(ifa.wr), .rd(ifa.rd),
    .rdata(ifa.rdata), .base_clock_out(ifa.base_clock_out),
    .osc_enable_from_integration(ifa.osc_enable_from_integration));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic near(input string nm, input int e, input int g);
    comparisons++;
    if (g < e - 1 || g > e + 1) begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    ifb.addr <= a;
    ifb.wdata <= d;
    ifb.wr <= 1'b1;
    @(posedge core_clk);
    ifb.wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    ifb.addr <= a;
    ifb.rd <= 1'b1;
    @(posedge core_clk);
    ifb.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), 32'(e), 32'(ifb.rdata));
    @(posedge core_clk);
  endtask

  task automatic cwr(input logic [2:0] a, input logic [31:0] v);
    cmd_addr <= a;
    cmd_wdata <= v;
    cmd_wr <= 1'b1;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // polls host status until busy drops
  task automatic wait_idle;
    n = 0;
    rv = 32'h1;
    while (rv[0] !== 1'b0 && n < 300) begin
      cmd_addr <= HOST_STATUS;
      cmd_rd <= 1'b1;
      @(posedge core_clk);
      cmd_rd <= 1'b0;
      #1 rv = cmd_rdata;
      @(posedge core_clk);
      n++;
    end
    chk("host busy", 32'h0, 32'(rv[0]));
  endtask

  task automatic measure(input string nm, input int ea, input int eb);
    ta = 0;
    tb = 0;
    repeat (WIN) @(posedge core_clk);
    near({nm, " a"}, ea, ta);
    near({nm, " b"}, eb, tb);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    fails++;
    $display("ERROR watchdog expected finish seen timeout");
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    {stop_mode, run_stop, cmd_wr, cmd_rd} = 4'h0;
    cmd_addr = 3'h0;
    cmd_wdata = 32'h0;
    {ifb.addr, ifb.wdata, ifb.wr, ifb.rd} = 18'h00000;
    ifb.osc_enable_from_integration = 1'b1;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    foreach (ra[i]) rchk(ra[i], re[i]);
    chk("mult eff", 32'h40, 32'(mul_b));
    measure("reset clk", XE, XE);
    $display("test reset done");
    dwr(8'h39, 8'h55);
    rchk(8'h39, 8'h40);
    dwr(8'h36, 8'h1F);
    rchk(8'h36, 8'h2F);
    dwr(8'h36, 8'h00);
    dwr(8'h36, 8'h10);
    rchk(8'h36, 8'h00);
    for (int i = 0; i < 4; i++) dwr(8'h38 + 8'(i), 8'h00);
    rchk(8'h3A, 8'h00);
    chk("mult zero", 32'h1, 32'(mul_b));
    chk("div zero", 32'h1, 32'(rdv_b));
    dwr(8'h36, 8'h20);
    dwr(8'h36, 8'h30);
    rchk(8'h36, 8'h20);
    chk("pll en", 32'h0, 32'(pe_b));
    dwr(8'h36, 8'h00);
    dwr(8'h3A, 8'h40);
    dwr(8'h36, 8'h20);
    chk("pll en", 32'h1, 32'(pe_b));
    dwr(8'h36, 8'h30);
    #1 chk("switching", 32'h1, 32'(sw_b));
    tb = 0;
    n = 0;
    while (sw_b !== 1'b0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk("switch bound", 32'h1, 32'(n <= SWB));
    chk("held base", 32'h0, 32'(tb));
    rchk(8'h36, 8'h30);
    measure("vco clk", XE, VE);
    dwr(8'h36, 8'h10);
    rchk(8'h36, 8'h30);
    dwr(8'h36, 8'h00);
    rchk(8'h36, 8'h30);
    $display("test interlock done");
    for (int i = 0; i < 3; i++) begin
      cwr(HOST_MULT, hm[i]);
      cwr(HOST_FREQ, hf[i]);
      cwr(HOST_REFDIV, 32'h1);
      cwr(HOST_CMD, 32'h1);
      wait_idle();
      chk("status", he[i], (i == 0) ? rv & 32'h3 : rv);
    end
    chk("prescale", 32'h0, 32'(pre_a));
    chk("range pow", 32'h2, 32'(vpr_a));
    chk("range", 32'h80, 32'(rng_a));
    chk("mult", 32'h258, 32'(mul_a));
    chk("ref div", 32'h1, 32'(rdv_a));
    repeat (SWB) @(posedge core_clk);
    measure("host vco", VE, VE);
    cwr(HOST_CMD, 32'h2);
    wait_idle();
    repeat (SWB) @(posedge core_clk);
    measure("host xtal", XE, VE);
    $display("test host done");
    for (int i = 0; i < 4; i++) begin
      stop_mode <= i[0];
      run_stop <= i[1];
      repeat (3) @(posedge core_clk);
      chk("osc en", 32'(!i[0] || i[1]), 32'(oe_a));
      chk("pll en", 32'(!i[0] || i[1]), 32'(pe_a));
    end
    $display("test osc done");
    print_verdict();
  end
endmodule
